// [shared/bst_pkg.sv]
// Shared definitions for the boundary-scan test access port.
// Assumes a single system clock that oversamples the test clock pin.
package bst_pkg;

	// ------------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------------
	localparam int          IR_W          = 16;
	localparam logic [15:0] OP_BYPASS0    = 16'h0000;
	localparam logic [15:0] OP_BYPASS1    = 16'hFFFF;
	localparam logic [15:0] OP_SAMPLE     = 16'hFFF8;
	localparam logic [15:0] OP_EXTEST     = 16'hFFE8;
	localparam logic [15:0] OP_CLAMP      = 16'hFFEF;
	localparam logic [15:0] OP_HIGHZ      = 16'hFFCF;
	localparam logic [15:0] OP_IDENT      = 16'hFFFE;
	localparam logic [15:0] OP_PRIVATE    = 16'hFFFD;
	// Fixed capture pattern of the instruction register (low bits 01).
	localparam logic [15:0] IR_CAPTURE    = 16'h0001;
	// Identity value; the value is arbitrary, bit 0 must be one.
	localparam logic [31:0] ID_VALUE      = 32'h0ABC_D001;
	localparam int          ID_W          = 32;
	localparam int          PRIV_W        = 8;
	// Test-Logic-Reset is forced after this many TMS-high rising edges.
	localparam logic [2:0]  TLR_EDGES     = 3'h5;

	// ------------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} bst_state_type;

	// Test pins seen by the block, already synchronised.
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bst_pins_type;

endpackage

// [sim/bst_tester.sv]
// Model of the external board tester that drives the test port pins.
// Assumes a 25 MHz bench clock; one test clock spans 8 bench clocks.
`timescale 1ns/100ps
module bst_tester (
	input  wire logic clock,
	input  wire logic tdo,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	// The test clock stands low between frames, as a real tester's does.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One test clock: TMS and TDI change while low, well clear of the rise.
	// Data out is read in the high phase, where it stands until the fall.
	task automatic step(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clock);
		tck <= 1'b1;
		repeat (2) @(posedge clock);
		o = tdo;
		repeat (2) @(posedge clock);
		tck <= 1'b0;
	endtask

	// Five clocks with TMS high reach Test-Logic-Reset, then go idle.
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask

	// From idle to a shift state, n bits LSB first, update, back to idle.
	task automatic scan(input logic ir, input logic [63:0] din,
		input int n, output logic [63:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir) begin
			step(1'b1, 1'b0, o);
		end
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// [sim/tb_boundary_scan_tap.sv]
// Self-checking bench for the test access port and its pin muxing.
// Assumes the tester model drives the test pins at 320 ns per clock.
`timescale 1ns/100ps
module tb_boundary_scan_tap;
	import bst_pkg::*;
	typedef struct {
		logic [15:0] op;
		int          len;
		logic [63:0] cap;
		logic        own;
	} bst_row_type;
	logic         clock     = 1'b0;
	logic         rst_n     = 1'b0;
	logic         test_mode = 1'b0;
	logic [7:0]   core_out  = 8'h5A;
	logic [7:0]   core_oe   = 8'h0F;
	logic [7:0]   pad_in    = 8'h96;
	logic         tck, tms, tdi, tdo, tdo_oe;
	logic         tdo_line;  // Board net seen by the tester.
	logic [7:0]   pad_out, pad_oe, core_in;
	logic [63:0]  d;
	bst_row_type  rows [8];
	int           err_total = 0;
	int           checked   = 0;
	int           cycles    = 0;

	always #20 clock = ~clock;

	// A released data-out line floats to its pull-up level.
	assign tdo_line = tdo_oe ? tdo : 1'b1;

	bst_tap #(.NPINS(8)) uut (.clock(clock), .rst_n(rst_n),
		.test_mode(test_mode), .tck_pin(tck), .tms_pin(tms),
		.tdi_pin(tdi), .tdo_q(tdo), .tdo_oe_q(tdo_oe),
		.core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
		.pad_out_q(pad_out), .pad_oe_q(pad_oe), .core_in_q(core_in));
	bst_tester u_tst (.clock(clock), .tdo(tdo_line), .tck(tck), .tms(tms),
		.tdi(tdi));

	// Compare one value and report a difference at once.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Load an instruction and let the registered pads settle.
	task automatic load_ir(input logic [15:0] op);
		u_tst.scan(1'b1, 64'(op), IR_W, d);
		repeat (6) @(posedge clock);
	endtask

	// A hang is cut short well above the expected run of some 4550 clocks.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		rows = '{'{OP_BYPASS0, 1, 64'h0, 1'b1},
			'{OP_BYPASS1, 1, 64'h0, 1'b1},
			'{OP_SAMPLE, 16, 64'({core_oe, pad_in}), 1'b1},
			'{OP_EXTEST, 16, 64'({core_oe, pad_in}), 1'b1},
			'{OP_CLAMP, 1, 64'h0, 1'b1},
			'{OP_HIGHZ, 1, 64'h0, 1'b1},
			'{OP_IDENT, ID_W, 64'(ID_VALUE), 1'b1},
			'{OP_PRIVATE, PRIV_W, 64'h0, 1'b0}};
		repeat (2) @(posedge clock);
		check({tdo, tdo_oe, pad_oe}, 64'h0);
		rst_n <= 1'b1;
		// Out of test mode the pins stay functional and edges are ignored.
		u_tst.reset5();
		u_tst.scan(1'b1, 64'(OP_EXTEST), IR_W, d);
		check(d, 64'hFFFF);
		check({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in});
		test_mode <= 1'b1;
		u_tst.reset5();
		u_tst.scan(1'b0, 64'h0, ID_W, d);
		check(d, 64'(ID_VALUE));
		// Every code: capture pattern and length; register capture for all but the private code.
		foreach (rows[i]) begin
			u_tst.scan(1'b1, 64'(rows[i].op), IR_W, d);
			check(d, 64'(IR_CAPTURE));
			u_tst.scan(1'b0, 64'hC3, rows[i].len + 8, d);
			if (rows[i].own)
				check(d & ((64'h1 << rows[i].len) - 1), rows[i].cap);
			check((d >> rows[i].len) & 64'hFF, 64'hC3);
		end
		// Preload, then drive, float and clamp the pins from the latch.
		load_ir(OP_SAMPLE);
		u_tst.scan(1'b0, 64'hC33C, 16, d);
		check({pad_out, pad_oe}, {core_out, core_oe});
		load_ir(OP_EXTEST);
		check({pad_out, pad_oe}, 16'h3CC3);
		load_ir(OP_HIGHZ);
		check(pad_oe, 8'h00);
		load_ir(OP_CLAMP);
		check({pad_out, pad_oe}, 16'h3CC3);
		test_mode <= 1'b0;
		repeat (4) @(posedge clock);
		check({pad_out, pad_oe}, {core_out, core_oe});
		test_mode <= 1'b1;
		load_ir(OP_EXTEST);
		u_tst.reset5();
		repeat (6) @(posedge clock);
		check({pad_out, pad_oe}, {core_out, core_oe});
		wrap_up();
	end
endmodule

// [src/bst_tap.sv]
// Boundary-scan test access port: controller, instruction register,
// bypass, identity, private and boundary registers, pin muxing.
// Assumes test pins come asynchronously and the clock is far faster
// than the test clock so that both its edges are seen.
//
// Notes on behaviour
// (R1) Sample TMS and TDI at test clock rise.
// (R2) Change data out at test clock fall.
// (R3) Standard sixteen-state controller and register behaviour.
// (R4) Sixteen-bit IR; zeros, ones bypass; sample code.
// (R5) Extest, clamp, highz decoded with standard effects.
// (R6) Identity register 32 bits; private register code.
// (R7) Pins are scan only in test mode.
// (R8) Every digital pin has a boundary cell.
// (R9) Four test signals; controller, data and instruction.
// (R10) Five TMS-high edges force Test-Logic-Reset.
// (R11) Reset loads identity instruction, pins normal; highz pins stay floated until the first test clock in reset.
`timescale 1ns/100ps
module bst_tap
	import bst_pkg::*;
#(
	parameter int NPINS = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             test_mode,
	input  wire logic             tck_pin,
	input  wire logic             tms_pin,
	input  wire logic             tdi_pin,
	output logic                  tdo_q,
	output logic                  tdo_oe_q,
	input  wire logic [NPINS-1:0] core_out,
	input  wire logic [NPINS-1:0] core_oe,
	input  wire logic [NPINS-1:0] pad_in,
	output logic      [NPINS-1:0] pad_out_q,
	output logic      [NPINS-1:0] pad_oe_q,
	output logic      [NPINS-1:0] core_in_q
);
	import bst_pkg::*;

	// ------------------------------------------------------------------
	// Synchronisers for test pins
	// ------------------------------------------------------------------
	// Two stages; only the second stage is read by logic.
	bst_pins_type meta_q, sync_q;
	logic [NPINS-1:0] pad_meta_q;  // Pad levels, first stage.
	logic [NPINS-1:0] pad_sync_q;  // Pad levels, second stage.
	logic         tck_old_q;   // Last synchronised test clock level.
	logic         rise;        // Test clock rising edge seen.
	logic         fall;        // Test clock falling edge seen.

	// Pins are gated by test mode so the port stays idle otherwise.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q    <= '0;
			sync_q    <= '0;
			tck_old_q <= 1'b0;
			pad_meta_q <= '0;
			pad_sync_q <= '0;
		end else begin
			meta_q    <= '{tck_pin, tms_pin, tdi_pin};
			sync_q    <= meta_q;
			tck_old_q <= sync_q.tck;
			// Pad levels come from the board, so they are resynchronised.
			pad_meta_q <= pad_in;
			pad_sync_q <= pad_meta_q;
		end
	end
	assign rise = test_mode & sync_q.tck & ~tck_old_q; // [R1] [R7]
	assign fall = test_mode & ~sync_q.tck & tck_old_q; // [R2]

	// ------------------------------------------------------------------
	// Controller and shift registers
	// ------------------------------------------------------------------
	bst_state_type          st_q, st_d;
	logic [IR_W-1:0]        ir_q, ir_d;        // Active instruction.
	logic [IR_W-1:0]        irs_q, irs_d;      // Instruction shifter.
	logic                   byp_q, byp_d;      // Bypass bit.
	logic [ID_W-1:0]        id_q, id_d;        // Identity shifter.
	logic [PRIV_W-1:0]      pv_q, pv_d;        // Private register.
	logic [2*NPINS-1:0]     bs_q, bs_d;        // Boundary shifter.
	logic [2*NPINS-1:0]     bu_q, bu_d;        // Boundary update latch.
	logic [2:0]             hi_q, hi_d;        // TMS-high run count.

	// Decode instruction class; used for capture, shift, update and data out.
	function automatic logic [2:0] dr_sel(input logic [IR_W-1:0] op);
		unique case (op)
			OP_SAMPLE, OP_EXTEST:   dr_sel = 3'h1; // [R4] [R5]
			OP_IDENT:               dr_sel = 3'h2; // [R6]
			OP_PRIVATE:             dr_sel = 3'h3; // [R6]
			default:                dr_sel = 3'h0; // Bypass [R4] [R5]
		endcase
	endfunction

	logic [2:0] sel;
	assign sel = dr_sel(ir_q);

	// Next-state logic of the sixteen-state controller.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_TLR:    st_d = sync_q.tms ? ST_TLR : ST_RTI;
			ST_RTI:    st_d = sync_q.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: st_d = sync_q.tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_d = sync_q.tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  st_d = sync_q.tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_d = sync_q.tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR:  st_d = sync_q.tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: st_d = sync_q.tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_d = sync_q.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: st_d = sync_q.tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: st_d = sync_q.tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  st_d = sync_q.tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_d = sync_q.tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR:  st_d = sync_q.tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: st_d = sync_q.tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_d = sync_q.tms ? ST_SEL_DR : ST_RTI;
		endcase
		// The state graph already reaches reset in five; the counter
		// guards against an illegal state after a glitch.
		hi_d = sync_q.tms ? ((hi_q == TLR_EDGES) ? hi_q : hi_q + 3'h1)
		                  : 3'h0;
		if (sync_q.tms && hi_q >= TLR_EDGES - 3'h1)
			st_d = ST_TLR; // [R10]
		if (!rise) begin
			st_d = st_q;
			hi_d = hi_q;
		end
	end

	// Register datapath, all acting on a test clock rising edge.
	always_comb begin
		ir_d  = ir_q;
		irs_d = irs_q;
		byp_d = byp_q;
		id_d  = id_q;
		pv_d  = pv_q;
		bs_d  = bs_q;
		bu_d  = bu_q;
		if (rise) begin
			unique case (st_q)
				ST_TLR:    ir_d  = OP_IDENT; // [R11]
				ST_CAP_IR: irs_d = IR_CAPTURE; // [R3]
				ST_SH_IR:  irs_d = {sync_q.tdi, irs_q[IR_W-1:1]};
				ST_UPD_IR: ir_d  = irs_q; // [R4]
				ST_CAP_DR: begin
					byp_d = 1'b0;
					id_d  = ID_VALUE; // [R6]
					if (sel == 3'h1)
						bs_d = {core_oe, pad_sync_q}; // [R8]
				end
				ST_SH_DR: begin
					unique case (sel)
						3'h1: bs_d = {sync_q.tdi, bs_q[2*NPINS-1:1]};
						3'h2: id_d = {sync_q.tdi, id_q[ID_W-1:1]};
						3'h3: pv_d = {sync_q.tdi, pv_q[PRIV_W-1:1]};
						default: byp_d = sync_q.tdi;
					endcase
				end
				ST_UPD_DR: begin
					if (sel == 3'h1)
						bu_d = bs_q; // [R5]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= ST_TLR;
			hi_q  <= 3'h0;
			ir_q  <= OP_IDENT;
			irs_q <= IR_CAPTURE;
			byp_q <= 1'b0;
			id_q  <= ID_VALUE;
			pv_q  <= '0;
			bs_q  <= '0;
			bu_q  <= '0;
		end else begin
			st_q  <= st_d;
			hi_q  <= hi_d;
			ir_q  <= ir_d;
			irs_q <= irs_d;
			byp_q <= byp_d;
			id_q  <= id_d;
			pv_q  <= pv_d;
			bs_q  <= bs_d;
			bu_q  <= bu_d;
		end
	end

	// ------------------------------------------------------------------
	// Data out and pin drive
	// ------------------------------------------------------------------
	logic             tdo_d, tdo_oe_d;
	logic [NPINS-1:0] pout_d, poe_d;
	logic             ext;  // Boundary update latch owns the pins.

	// Pins: extest and clamp drive latched values, highz floats all.
	// Extest and clamp pins return to normal use as soon as the controller is in reset;
	// highz pins stay floated until the instruction reloads one test clock later.
	assign ext = test_mode && st_q != ST_TLR
		&& (ir_q == OP_EXTEST || ir_q == OP_CLAMP); // [R11]

	always_comb begin
		tdo_d    = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (fall) begin // [R2]
			tdo_oe_d = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
			if (st_q == ST_SH_IR)
				tdo_d = irs_q[0];
			else
				unique case (sel)
					3'h1:    tdo_d = bs_q[0];
					3'h2:    tdo_d = id_q[0];
					3'h3:    tdo_d = pv_q[0];
					default: tdo_d = byp_q;
				endcase
		end
		if (!test_mode)
			tdo_oe_d = 1'b0; // [R7] [R9]
		pout_d = ext ? bu_q[NPINS-1:0] : core_out; // [R5] [R8]
		poe_d  = ext ? bu_q[2*NPINS-1:NPINS] : core_oe;
		if (test_mode && ir_q == OP_HIGHZ)
			poe_d = '0; // [R5]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tdo_q     <= 1'b0;
			tdo_oe_q  <= 1'b0;
			pad_out_q <= '0;
			pad_oe_q  <= '0;
			core_in_q <= '0;
		end else begin
			tdo_q     <= tdo_d;
			tdo_oe_q  <= tdo_oe_d;
			pad_out_q <= pout_d;
			pad_oe_q  <= poe_d;
			core_in_q <= pad_sync_q;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_tms_run;
		rise && sync_q.tms && (st_q == ST_SH_IR || st_q == ST_SH_DR);
	endsequence

	chk_reset_reach: assert property ( // [R10]
		(hi_q == TLR_EDGES) |-> st_q == ST_TLR)
		else $error("Controller not in reset after TMS run.");
	chk_tlr_ident: assert property ( // [R11]
		(st_q == ST_TLR && rise) |=> ir_q == OP_IDENT)
		else $error("Reset did not load identity instruction.");
	chk_still_no_edge: assert property ( // [R1]
		!rise |=> $stable(st_q))
		else $error("Controller moved without test clock rise.");
	chk_tdo_on_fall: assert property ( // [R2]
		!fall |=> $stable(tdo_q))
		else $error("Data out changed off the falling edge.");
	chk_idle_no_tdo: assert property ( // [R7]
		!test_mode |=> !tdo_oe_q)
		else $error("Data out driven outside test mode.");
	chk_highz_pins: assert property ( // [R5]
		(test_mode && ir_q == OP_HIGHZ) |=> pad_oe_q == '0)
		else $error("Pins driven under highz.");
	chk_ir_update: assert property ( // [R4]
		(rise && st_q == ST_UPD_IR) |=> ir_q == $past(irs_q))
		else $error("Instruction not updated.");
	chk_id_capture: assert property ( // [R6]
		(rise && st_q == ST_CAP_DR) |=> id_q == ID_VALUE)
		else $error("Identity not captured.");
	chk_tms_step: assert property ( // [R3]
		s_tms_run |=> st_q == (($past(st_q) == ST_SH_IR) ? ST_EX1_IR
		                                                 : ST_EX1_DR))
		else $error("Controller step wrong on TMS high.");
	chk_normal_pins: assert property ( // [R7]
		!test_mode |=> pad_out_q == $past(core_out))
		else $error("Pins not in normal use outside test mode.");

endmodule
